// ---- logic/csw_pkg.sv ----
// Purpose: constants shared by the scrub shim wrapper
// Assumes: 50 MHz master clock
// Notes: one name for every number used by the wrapper
package csw_pkg;
  // Clock and serial timing
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned BAUD = 115200;
  localparam int unsigned OVERSAMPLE = 16;
  localparam int unsigned TICK_DIV = CLK_HZ / (BAUD * OVERSAMPLE);
  localparam logic [4:0] TICK_LAST = 5'(TICK_DIV - 1);
  localparam logic [3:0] OS_LAST = 4'hf;
  localparam logic [3:0] OS_MID = 4'h7;
  localparam logic [3:0] CHAR_BITS = 4'h8;
  localparam logic [3:0] TX_FRAME_LAST = 4'h9;
  // Self initialisation length
  localparam logic [3:0] POR_LAST = 4'hf;
  // Flash read framing
  localparam logic [7:0] FLASH_READ_CMD = 8'h03;
  localparam logic [5:0] HDR_BITS = 6'h20;
  localparam logic [2:0] BYTE_LAST = 3'h7;
  // Region id field inside the device id word
  localparam int unsigned REGION_LSB = 28;
  localparam int unsigned REGION_W = 2;
  // Controller modes
  typedef enum logic [1:0] {
    CSW_MODE_INIT = 2'b00,
    CSW_MODE_OBSERVE = 2'b01,
    CSW_MODE_CORRECT = 2'b10,
    CSW_MODE_IDLE = 2'b11
  } csw_mode_t;
  // Flash fetch sequencer states
  typedef enum logic [1:0] {
    CSW_SPI_IDLE = 2'b00,
    CSW_SPI_HDR = 2'b01,
    CSW_SPI_DATA = 2'b10,
    CSW_SPI_DONE = 2'b11
  } csw_spi_t;
endpackage

// ---- logic/csw_wrapper.sv ----
// Purpose: shim wrapper around a configuration scrubbing controller
// Assumes: mclk arrives already on the global clock network
// Notes: no reset pin; state self-initialises from power-up values
// Operation
// RULE1 - config memory reads only in observe or init, writes init/correct
// RULE2 - no reset port; wrapper initialises itself then its shims
// RULE3 - every flip-flop clocks on the rising edge of mclk
// RULE4 - master clock reaches all logic over a global clock buffer
// RULE5 - host serial shim always present for commands and status
// RULE6 - status bytes are sent serially on the transmit line
// RULE7 - received serial characters become parallel command bytes
// RULE8 - receive line is synchronised and oversampled sixteen times
// RULE9 - both serial lines are active low, remote drives same sense
// RULE10 - flash fetch shim exists only when external data is needed
// RULE11 - fetch request carries a start address and byte count
// RULE12 - each request runs a flash read and returns bytes to controller
// RULE13 - SPI mode 0: clock idles low, sample rising, change falling
// RULE14 - SPI clock is exactly half the master clock
// RULE15 - region number read from device id register via config port
// RULE16 - exchanges use hardware region numbers, master is zero
// RULE17 - on stacked parts each status output has one bit per region
// RULE18 - controller status passes straight to wrapper status ports
// RULE19 - shim drives SPI clock, data out, select; takes data in
// RULE20 - select held low for a whole request, released between
// RULE21 - serial character: start, eight data LSB first, one stop
module csw_wrapper #(
  parameter int unsigned NUM_REGIONS = 1,
  parameter bit HAS_FLASH = 1'b1
) (
  // Clock
  input wire logic mclk,
  // Controller status, passed through
  input wire logic [NUM_REGIONS-1:0] ctrl_stat_init,
  input wire logic [NUM_REGIONS-1:0] ctrl_stat_observe,
  input wire logic [NUM_REGIONS-1:0] ctrl_stat_correct,
  input wire logic [NUM_REGIONS-1:0] ctrl_stat_fatal,
  output logic [NUM_REGIONS-1:0] stat_init,
  output logic [NUM_REGIONS-1:0] stat_observe,
  output logic [NUM_REGIONS-1:0] stat_correct,
  output logic [NUM_REGIONS-1:0] stat_fatal,
  // Controller config port access
  input wire csw_pkg::csw_mode_t ctrl_mode,
  input wire logic cfg_rd_req,
  input wire logic cfg_wr_req,
  input wire logic [31:0] cfg_rdata,
  output logic cfg_rd,
  output logic cfg_wr,
  output logic [csw_pkg::REGION_W-1:0] region_id,
  output logic init_done,
  // Status byte stream into the serial shim
  input wire logic [7:0] status_byte,
  input wire logic status_valid,
  output logic status_ready,
  // Command bytes out of the serial shim
  output logic [7:0] cmd_byte,
  output logic cmd_valid,
  // Serial lines
  input wire logic host_rx,
  output logic host_tx,
  // Fetch requests
  input wire logic fetch_req,
  input wire logic [31:0] fetch_addr,
  input wire logic [15:0] fetch_count,
  output logic fetch_busy,
  output logic [7:0] fetch_data,
  output logic fetch_data_valid,
  // SPI flash pins
  input wire logic flash_miso,
  output logic flash_clk,
  output logic flash_mosi,
  output logic flash_sel_n
);
  import csw_pkg::*;

  // Straight pass-through, no register in the path
  assign stat_init = ctrl_stat_init; // RULE18 RULE17
  assign stat_observe = ctrl_stat_observe; // RULE18 RULE17
  assign stat_correct = ctrl_stat_correct; // RULE18 RULE17
  assign stat_fatal = ctrl_stat_fatal; // RULE18 RULE17

  // mclk is the global-buffered net; one domain, rising edge only
  // RULE4 RULE3
  logic [3:0] por_cnt = 4'h0; // RULE2
  logic por_busy = 1'b1;
  always_ff @(posedge mclk) begin // RULE2
    if (por_busy) begin
      por_cnt <= por_cnt + 4'h1;
      por_busy <= (por_cnt != POR_LAST);
    end
  end

  // Mode gating of requested reads and writes; the id read after power-up goes out in any mode
  wire rd_ok = (ctrl_mode == CSW_MODE_OBSERVE) ||
               (ctrl_mode == CSW_MODE_INIT); // RULE1
  wire wr_ok = (ctrl_mode == CSW_MODE_CORRECT) ||
               (ctrl_mode == CSW_MODE_INIT); // RULE1
  logic id_pend;
  logic id_wait;
  always_ff @(posedge mclk) begin
    if (por_busy) begin
      cfg_rd <= 1'b0;
      cfg_wr <= 1'b0;
      id_pend <= 1'b1;
      id_wait <= 1'b0;
      region_id <= '0; // RULE16
      init_done <= 1'b0;
    end else begin
      cfg_rd <= id_pend || (cfg_rd_req && rd_ok); // RULE1 RULE15
      cfg_wr <= cfg_wr_req && wr_ok && !id_pend; // RULE1
      id_pend <= 1'b0;
      id_wait <= id_pend;
      if (id_wait) begin
        // Hardware region number straight from the id word
        region_id <= cfg_rdata[REGION_LSB +: REGION_W]; // RULE15 RULE16
        init_done <= 1'b1; // RULE2
      end
    end
  end

  // Oversample tick divider, shared by both serial directions
  logic [4:0] tick_cnt;
  logic tick;
  always_ff @(posedge mclk) begin
    if (por_busy || tick_cnt == TICK_LAST) begin
      tick_cnt <= 5'h0;
    end else begin
      tick_cnt <= tick_cnt + 5'h1;
    end
    tick <= !por_busy && (tick_cnt == TICK_LAST);
  end

  // Transmitter: sixteen ticks per bit, idle line high
  logic [9:0] tx_shift;
  logic [3:0] tx_bit;
  logic [3:0] tx_os;
  logic tx_busy;
  wire tx_load = !tx_busy && status_valid && status_ready;
  always_ff @(posedge mclk) begin // RULE5 RULE6
    if (por_busy) begin
      tx_busy <= 1'b0;
      host_tx <= 1'b1; // RULE9
      status_ready <= 1'b0;
      tx_shift <= 10'h3ff;
      tx_bit <= 4'h0;
      tx_os <= 4'h0;
    end else if (tx_load) begin
      tx_shift <= {1'b1, status_byte, 1'b0}; // RULE21
      tx_busy <= 1'b1;
      status_ready <= 1'b0;
      tx_bit <= 4'h0;
      tx_os <= 4'h0;
    end else if (tx_busy && tick) begin
      host_tx <= tx_shift[0]; // RULE9 RULE21
      tx_os <= tx_os + 4'h1;
      if (tx_os == OS_LAST) begin
        tx_shift <= {1'b1, tx_shift[9:1]};
        tx_bit <= tx_bit + 4'h1;
        if (tx_bit == TX_FRAME_LAST) begin
          tx_busy <= 1'b0;
          host_tx <= 1'b1;
        end
      end
    end else begin
      status_ready <= !tx_busy;
    end
  end

  // Receive synchroniser; first stage feeds only the second
  logic rx_meta;
  logic rx_sync;
  always_ff @(posedge mclk) begin // RULE8
    rx_meta <= host_rx;
    rx_sync <= rx_meta;
  end

  // Receiver: find start edge, sample each bit in its middle
  logic rx_busy;
  logic [3:0] rx_os;
  logic [3:0] rx_bit;
  logic [7:0] rx_shift;
  always_ff @(posedge mclk) begin // RULE7 RULE8
    if (por_busy) begin
      rx_busy <= 1'b0;
      rx_os <= 4'h0;
      rx_bit <= 4'h0;
      rx_shift <= 8'h00;
      cmd_byte <= 8'h00;
      cmd_valid <= 1'b0;
    end else begin
      cmd_valid <= 1'b0;
      if (!rx_busy) begin
        if (tick && !rx_sync) begin // RULE9
          rx_busy <= 1'b1;
          rx_os <= 4'h0;
          rx_bit <= 4'h0;
        end
      end else if (tick) begin
        rx_os <= rx_os + 4'h1;
        if (rx_bit == 4'h0 && rx_os == OS_MID) begin
          // Start bit re-checked mid bit; a glitch is dropped
          rx_busy <= !rx_sync;
          rx_os <= 4'h0;
          rx_bit <= 4'h1;
        end else if (rx_bit != 4'h0 && rx_os == OS_LAST) begin
          rx_os <= 4'h0;
          rx_bit <= rx_bit + 4'h1;
          if (rx_bit <= CHAR_BITS) begin
            rx_shift <= {rx_sync, rx_shift[7:1]}; // RULE21
          end else begin
            // Stop bit must be high, else the character is lost
            rx_busy <= 1'b0;
            cmd_byte <= rx_shift; // RULE7
            cmd_valid <= rx_sync; // RULE21
          end
        end
      end
    end
  end

  // Flash fetch shim, built only when the controller needs it
  generate
    if (HAS_FLASH) begin : g_flash // RULE10
      csw_spi_t sp_state;
      logic ph;
      logic [31:0] hdr;
      logic [5:0] hdr_left;
      logic [15:0] bytes_left;
      logic [2:0] bit_idx;
      logic [7:0] rx_byte;
      wire [7:0] next_byte = {rx_byte[6:0], flash_miso};
      always_ff @(posedge mclk) begin // RULE11 RULE12
        if (por_busy) begin
          sp_state <= CSW_SPI_IDLE;
          ph <= 1'b0;
          hdr <= 32'h0;
          hdr_left <= 6'h0;
          bytes_left <= 16'h0;
          bit_idx <= 3'h0;
          rx_byte <= 8'h00;
          flash_clk <= 1'b0; // RULE13
          flash_mosi <= 1'b0;
          flash_sel_n <= 1'b1; // RULE20
          fetch_busy <= 1'b0;
          fetch_data <= 8'h00;
          fetch_data_valid <= 1'b0;
        end else begin
          fetch_data_valid <= 1'b0;
          case (sp_state)
            CSW_SPI_IDLE: begin
              flash_clk <= 1'b0;
              ph <= 1'b0;
              if (fetch_req && fetch_count != 16'h0) begin // RULE11
                hdr <= {FLASH_READ_CMD, fetch_addr[23:0]};
                flash_mosi <= FLASH_READ_CMD[7];
                bytes_left <= fetch_count;
                hdr_left <= HDR_BITS;
                bit_idx <= 3'h0;
                flash_sel_n <= 1'b0; // RULE20 RULE19
                fetch_busy <= 1'b1;
                sp_state <= CSW_SPI_HDR;
              end
            end
            CSW_SPI_HDR: begin
              // Clock toggles every mclk: half the master rate
              ph <= !ph; // RULE14
              flash_clk <= !ph; // RULE13 RULE14
              if (ph) begin
                // Falling edge: present the next header bit
                hdr <= {hdr[30:0], 1'b0}; // RULE13
                flash_mosi <= hdr[30];
                hdr_left <= hdr_left - 6'h1;
                if (hdr_left == 6'h1) begin
                  sp_state <= CSW_SPI_DATA;
                end
              end
            end
            CSW_SPI_DATA: begin
              ph <= !ph; // RULE14
              flash_clk <= !ph; // RULE13
              if (!ph) begin
                // Rising edge: flash output is stable here
                rx_byte <= next_byte; // RULE13
                bit_idx <= bit_idx + 3'h1;
                if (bit_idx == BYTE_LAST) begin
                  fetch_data <= next_byte; // RULE12
                  fetch_data_valid <= 1'b1;
                  bytes_left <= bytes_left - 16'h1;
                  if (bytes_left == 16'h1) begin
                    sp_state <= CSW_SPI_DONE;
                  end
                end
              end
            end
            CSW_SPI_DONE: begin
              // Last falling edge and select release in the same mclk cycle
              flash_clk <= 1'b0;
              flash_sel_n <= 1'b1; // RULE20
              fetch_busy <= 1'b0;
              ph <= 1'b0;
              sp_state <= CSW_SPI_IDLE;
            end
            default: begin
              sp_state <= CSW_SPI_IDLE;
            end
          endcase
        end
      end
    end else begin : g_no_flash
      // Absent shim: pins parked in their idle levels
      always_ff @(posedge mclk) begin // RULE10
        flash_clk <= 1'b0;
        flash_mosi <= 1'b0;
        flash_sel_n <= 1'b1;
        fetch_busy <= 1'b0;
        fetch_data <= 8'h00;
        fetch_data_valid <= 1'b0;
      end
    end
  endgenerate
endmodule

// ---- dv/csw_flash_model.sv ----
// Purpose: behavioural serial flash on the far side of the fetch shim
// Assumes: read command plus 24-bit address, then data bytes
// Notes: byte i of a read is low address byte plus i
module csw_flash_model (
  // SPI pins
  input wire logic flash_clk,
  input wire logic flash_mosi,
  input wire logic flash_sel_n,
  output logic flash_miso
);
  logic [31:0] hdr;
  logic [7:0] bv;
  int n = 0;
  initial flash_miso = 1'b0;
  // Header taken on the rising clock edge
  always @(posedge flash_clk) begin
    if (!flash_sel_n && n < 32) hdr = {hdr[30:0], flash_mosi};
    n = n + 1;
  end
  // Data changes on the falling edge, MSB first; released line inverts
  // so a stale last bit cannot be mistaken for data
  always @(negedge flash_clk or posedge flash_sel_n) begin
    if (flash_sel_n) begin
      flash_miso = ~flash_miso;
    end else if (n >= 32) begin
      bv = hdr[7:0] + 8'((n - 32) / 8);
      flash_miso = bv[7 - (n - 32) % 8];
    end
  end
  always @(negedge flash_sel_n) n = 0;
endmodule

// ---- dv/csw_checker.sv ----
// Purpose: port level assertions for the wrapper
// Assumes: power-up register values, no reset pin
// Notes: attached by bind below
module csw_checker #(
  parameter int unsigned NUM_REGIONS = 1
) (
  // Clock and status
  input wire logic mclk,
  input wire logic [NUM_REGIONS-1:0] ctrl_stat_fatal,
  input wire logic [NUM_REGIONS-1:0] stat_fatal,
  // Config port
  input wire csw_pkg::csw_mode_t ctrl_mode,
  input wire logic cfg_rd_req,
  input wire logic cfg_wr_req,
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic init_done,
  // Serial
  input wire logic status_valid,
  input wire logic status_ready,
  input wire logic host_tx,
  // Flash
  input wire logic fetch_busy,
  input wire logic flash_clk,
  input wire logic flash_mosi,
  input wire logic flash_sel_n
);
  import csw_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  // Config strobes follow mode gating
  chk_rd_gate: assert property (
    init_done && cfg_rd_req && ctrl_mode inside {CSW_MODE_INIT,
    CSW_MODE_OBSERVE} |=> cfg_rd) else $error("read strobe missing");
  chk_wr_gate: assert property (
    cfg_wr |-> $past(cfg_wr_req) && $past(ctrl_mode) inside
    {CSW_MODE_INIT, CSW_MODE_CORRECT}) else $error("bad write strobe");
  chk_stat_copy: assert property (
    stat_fatal == ctrl_stat_fatal) else $error("status not passed");
  // SPI framing
  chk_clk_idle: assert property (
    flash_sel_n |-> !flash_clk) else $error("clock not idle low");
  chk_clk_half: assert property (
    flash_clk |=> !flash_clk ##1 (flash_clk || flash_sel_n))
    else $error("clock not at half rate");
  chk_mosi_edge: assert property (
    !flash_sel_n && $changed(flash_mosi) |-> !flash_clk)
    else $error("data changed on rising edge");
  // Guarded by init_done: outputs hold no value before the first edge
  chk_sel_busy: assert property (
    init_done |-> fetch_busy == !flash_sel_n)
    else $error("select not tied to request");
  // Serial transmit start
  chk_tx_start: assert property (
    status_valid && status_ready |=> !status_ready ##[1:28] !host_tx)
    else $error("no start bit");
  chk_tx_idle: assert property (
    status_ready |-> host_tx) else $error("idle line not high");
endmodule

bind csw_wrapper csw_checker #(.NUM_REGIONS(NUM_REGIONS)) i_csw_checker (
  .mclk, .ctrl_stat_fatal, .stat_fatal, .ctrl_mode, .cfg_rd_req,
  .cfg_wr_req, .cfg_rd, .cfg_wr, .init_done, .status_valid,
  .status_ready, .host_tx, .fetch_busy, .flash_clk, .flash_mosi,
  .flash_sel_n);

// ---- dv/csw_wrapper_test.sv ----
// Purpose: self-checking bench for the shim wrapper
// Assumes: no reset pin, wait out power-up init
// Notes: random data from a fixed seed plus corner values
module csw_wrapper_test;
  timeunit 1ns;
  timeprecision 1ps;
  import csw_pkg::*;
  localparam int NR = 2;
  localparam int BIT = OVERSAMPLE * TICK_DIV;
  logic mclk = 1'b0;
  logic [NR-1:0] ctrl_stat_init, ctrl_stat_observe, ctrl_stat_correct;
  logic [NR-1:0] ctrl_stat_fatal, stat_init, stat_observe, stat_correct;
  logic [NR-1:0] stat_fatal;
  csw_mode_t ctrl_mode;
  logic cfg_rd_req, cfg_wr_req, cfg_rd, cfg_wr, init_done, status_valid;
  logic status_ready, cmd_valid, host_rx, host_tx, fetch_req, fetch_busy;
  logic fetch_data_valid, flash_miso, flash_clk, flash_mosi, flash_sel_n;
  logic [31:0] cfg_rdata, fetch_addr;
  logic [15:0] fetch_count;
  logic [7:0] status_byte, cmd_byte, fetch_data;
  logic [REGION_W-1:0] region_id;
  int seed = 14;
  int n_mismatch = 0;
  int checked = 0;
  int k;

  csw_wrapper #(.NUM_REGIONS(NR)) i_csw_wrapper (.mclk, .ctrl_stat_init,
    .ctrl_stat_observe, .ctrl_stat_correct, .ctrl_stat_fatal, .stat_init,
    .stat_observe, .stat_correct, .stat_fatal, .ctrl_mode, .cfg_rd_req,
    .cfg_wr_req, .cfg_rdata, .cfg_rd, .cfg_wr, .region_id, .init_done,
    .status_byte, .status_valid, .status_ready, .cmd_byte, .cmd_valid,
    .host_rx, .host_tx, .fetch_req, .fetch_addr, .fetch_count, .fetch_busy,
    .fetch_data, .fetch_data_valid, .flash_miso, .flash_clk, .flash_mosi,
    .flash_sel_n);
  csw_flash_model i_csw_flash_model (.flash_clk, .flash_mosi, .flash_sel_n,
    .flash_miso);

  // Clock
  initial forever #10 mclk = ~mclk;

  // Expected flash byte and gating
  function automatic logic [7:0] fl_byte(logic [31:0] a, int i);
    return a[7:0] + 8'(i);
  endfunction
  function automatic logic rd_ok(int m);
    return m == CSW_MODE_INIT || m == CSW_MODE_OBSERVE;
  endfunction

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic hang(string what);
    check(what, 0, 1);
    conclude();
  endtask

  // Send one byte out and sample the line mid bit
  task automatic tx_char(logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    @(posedge mclk);
    status_byte <= b;
    status_valid <= 1'b1;
    @(posedge mclk);
    status_valid <= 1'b0;
    k = 0;
    while (host_tx !== 1'b0 && k < 100) begin
      @(negedge mclk);
      k++;
    end
    if (k == 100) hang("tx start");
    repeat (BIT / 2) @(negedge mclk);
    for (int i = 0; i < 10; i++) begin
      check("host_tx", host_tx, fr[i]);
      repeat (BIT) @(negedge mclk);
    end
  endtask

  // Drive one frame in, watch for the command pulse
  task automatic rx_char(logic [7:0] b);
    logic [9:0] fr;
    logic seen;
    fr = {1'b1, b, 1'b0};
    seen = 1'b0;
    for (int i = 0; i < 10; i++) begin
      @(posedge mclk);
      host_rx <= fr[i];
      // Full bit period so the frame does not drift against the receiver
      repeat (BIT) begin
        @(negedge mclk);
        if (cmd_valid === 1'b1) seen = 1'b1;
      end
    end
    check("cmd_valid", seen, 1);
    check("cmd_byte", cmd_byte, b);
  endtask

  // One fetch request, bytes checked against the flash model
  task automatic fetch(logic [31:0] a, logic [15:0] n);
    @(posedge mclk);
    fetch_req <= 1'b1;
    fetch_addr <= a;
    fetch_count <= n;
    @(posedge mclk);
    fetch_req <= 1'b0;
    for (int i = 0; i < n; i++) begin
      k = 0;
      do begin
        @(negedge mclk);
        k++;
      end while (fetch_data_valid !== 1'b1 && k < 200);
      if (k == 200) hang("fetch data");
      check("fetch_data", fetch_data, fl_byte(a, i));
    end
    repeat (2) @(negedge mclk);
    check("flash_sel_n", flash_sel_n, 1);
    check("header", i_csw_flash_model.hdr, {FLASH_READ_CMD, a[23:0]});
  endtask

  // Watchdog
  initial begin
    repeat (100000) @(posedge mclk);
    hang("watchdog");
  end

  initial begin
    ctrl_mode = CSW_MODE_INIT;
    {cfg_rd_req, cfg_wr_req, status_valid, fetch_req} = 4'h0;
    {ctrl_stat_init, ctrl_stat_observe} = 4'h0;
    {ctrl_stat_correct, ctrl_stat_fatal} = 4'h0;
    host_rx = 1'b1;
    cfg_rdata = $random(seed);
    status_byte = 8'h00;
    fetch_addr = 32'h0;
    fetch_count = 16'h0;
    repeat (24) @(posedge mclk);
    #1;
    check("init_done", init_done, 1);
    check("region_id", region_id, cfg_rdata[REGION_LSB+:REGION_W]);
    // Status copies, one bit per region
    repeat (4) begin
      @(posedge mclk);
      {ctrl_stat_init, ctrl_stat_observe, ctrl_stat_correct,
        ctrl_stat_fatal} <= 8'($random(seed));
      #1;
      check("stat", {stat_init, stat_observe, stat_correct, stat_fatal},
        {ctrl_stat_init, ctrl_stat_observe, ctrl_stat_correct,
        ctrl_stat_fatal});
    end
    // Every mode with read and write requests
    for (int m = 0; m < 4; m++) begin
      for (int w = 0; w < 2; w++) begin
        @(posedge mclk);
        ctrl_mode <= csw_mode_t'(m);
        cfg_rd_req <= w == 0;
        cfg_wr_req <= w == 1;
        @(posedge mclk);
        cfg_rd_req <= 1'b0;
        cfg_wr_req <= 1'b0;
        #1;
        check("cfg_rd", cfg_rd, w == 0 && rd_ok(m));
        check("cfg_wr", cfg_wr, w == 1 && m != 1 && m != 3);
      end
    end
    tx_char(8'h00);
    tx_char(8'hff);
    tx_char(8'($random(seed)));
    rx_char(8'h80);
    rx_char(8'($random(seed)));
    // Zero count is refused
    @(posedge mclk);
    fetch_req <= 1'b1;
    @(posedge mclk);
    fetch_req <= 1'b0;
    @(negedge mclk);
    check("fetch_busy", fetch_busy, 0);
    fetch(32'h00ab_cdfe, 16'h0003);
    fetch(32'($random(seed)), 16'h0001);
    fetch(32'($random(seed)), 16'(1 + $unsigned($random(seed)) % 4));
    conclude();
  end
endmodule
